// ---- hw/sgp_policy_regs.sv ----
`timescale 1ns/100ps
// What this block does
// (RL1) Aging runs when enabled; strap default on
// (RL2) Fast age bit selects 800us period
// (RL3) Aggressive back-off bit; strap default off
// (RL4) VLAN discard bit blocks all crossing traffic
// (RL5) Storm bit limits regulation to broadcast
// (RL6) Back pressure: carrier sense or collision
// (RL7) Fair mode drops non flow-controlled packets
// (RL8) Unfair mode flow-controls the flow-controlled port
// (RL9) Collision retry bit; strap default drop
// (RL10) Huge bit allows 1916 bytes, overrides
// (RL11) Otherwise size comes from legal bit
// (RL12) Legal bit: 1536, else 1522/1518
// (RL13) After fast cycle return to normal period
// (RL14) Straps load defaults, software may change
module sgp_policy_regs #(
    parameter logic [35:0] FAST_AGE_CYC   = sgp_pkg::AGE_FAST_CYC,   // Fast age period
    parameter logic [35:0] NORMAL_AGE_CYC = sgp_pkg::AGE_NORMAL_CYC  // Normal age period
) (
    input  wire logic                 CLOCK,                // Core clock, 40 MHz
    input  wire logic                 RST_N,                // Asynchronous reset
    input  wire logic                 AGING_DEFAULT_STRAP_PIN,     // Aging default
    input  wire logic                 BACKOFF_DEFAULT_STRAP_PIN,   // Back-off default
    input  wire logic                 COLLISION_DROP_DEFAULT_STRAP_PIN, // Retry default
    input  wire logic                 LEGAL_SIZE_DEFAULT_STRAP_PIN,     // Legal size default
    input  wire logic [7:0]           REG_ADDR,             // Register address
    input  wire logic                 REG_WR,               // Write strobe
    input  wire logic [7:0]           REG_WDATA,            // Write data
    output logic      [7:0]           REG_RDATA,            // Read data, one cycle later
    output logic                      AGE_TICK,             // One aging pass due
    output sgp_pkg::sgp_policy_t      POLICY                // Policy to the datapath
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic                 rst_s1_q;     // First synchroniser stage
    logic                 rst_s2_q;     // Released reset copy
    logic                 rst_n;        // Internal active-low reset

    // Release through two stages so every flop leaves reset together
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // ****************************************************************
    // Decode
    // ****************************************************************
    sgp_pkg::sgp_phase_t  phase_q;      // Strap load or running
    sgp_pkg::sgp_phase_t  phase_d;
    logic                 run;          // Software writes accepted
    logic                 wr_aging;     // Write to aging control
    logic                 wr_policy;    // Write to policy control
    logic                 fast_done;    // Fast pass issued this cycle

    assign run       = (phase_q == sgp_pkg::PH_RUN);
    // Writes are refused during the strap load cycle
    assign wr_aging  = run && REG_WR && (REG_ADDR == sgp_pkg::REG_AGING_CTRL_OFS);
    assign wr_policy = run && REG_WR && (REG_ADDR == sgp_pkg::REG_POLICY_CTRL_OFS);

    // Strap load happens once, on the first edge after release
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            sgp_pkg::PH_STRAP: phase_d = sgp_pkg::PH_RUN;
            sgp_pkg::PH_RUN:   phase_d = sgp_pkg::PH_RUN;
            default:           phase_d = sgp_pkg::PH_STRAP;
        endcase
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= sgp_pkg::PH_STRAP;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [2:0]           aging_q;      // Aging control bits
    logic [2:0]           aging_d;
    logic [7:0]           policy_q;     // Policy control bits
    logic [7:0]           policy_d;

    // Next value: strap load, software write, or fast age completion
    always_comb begin
        aging_d  = aging_q;
        policy_d = policy_q;
        if (!run) begin
            // Pins are sampled as reset leaves, then left to software
            aging_d[sgp_pkg::AG_AGE_EN_BIT]      = AGING_DEFAULT_STRAP_PIN;      // RL1 RL14
            aging_d[sgp_pkg::AG_BACKOFF_BIT]     = BACKOFF_DEFAULT_STRAP_PIN;    // RL3 RL14
            policy_d[sgp_pkg::PC_COLL_RETRY_BIT] = COLLISION_DROP_DEFAULT_STRAP_PIN; // RL9
            policy_d[sgp_pkg::PC_LEGAL_BIT]      = LEGAL_SIZE_DEFAULT_STRAP_PIN; // RL14
        end else begin
            // Fast aging ends itself after one pass
            if (fast_done) begin
                aging_d[sgp_pkg::AG_FAST_BIT] = 1'b0;                           // RL13
            end
            // A write in the same cycle wins over the self-clear
            if (wr_aging) begin
                aging_d = REG_WDATA[2:0] & sgp_pkg::AG_WRITE_MASK;
            end
            if (wr_policy) begin
                policy_d = REG_WDATA;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            aging_q  <= sgp_pkg::AG_RESET;                                       // RL2
            policy_q <= sgp_pkg::PC_RESET;
        end else begin
            aging_q  <= aging_d;
            policy_q <= policy_d;
        end
    end

    // ****************************************************************
    // Read back
    // ****************************************************************
    logic [7:0]           rdata_d;      // Selected register

    // Unmapped offsets read zero; the aging register keeps only 3 bits
    assign rdata_d = (REG_ADDR == sgp_pkg::REG_AGING_CTRL_OFS)  ? {5'h00, aging_q} :
                     (REG_ADDR == sgp_pkg::REG_POLICY_CTRL_OFS) ? policy_q : 8'h00;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= rdata_d;
        end
    end

    // ****************************************************************
    // Aging timer
    // ****************************************************************
    logic [35:0]          age_cnt_q;    // Cycles since last pass
    logic [35:0]          age_limit;    // Period in use
    logic                 age_due;      // Period elapsed
    logic                 age_en;
    logic                 fast_en;

    assign age_en    = aging_q[sgp_pkg::AG_AGE_EN_BIT];
    assign fast_en   = aging_q[sgp_pkg::AG_FAST_BIT];
    assign age_limit = fast_en ? FAST_AGE_CYC : NORMAL_AGE_CYC;                  // RL2 RL13
    assign age_due   = age_en && (age_cnt_q >= age_limit - 36'h1);
    assign fast_done = age_due && fast_en;

    // Held at zero while aging is off so a restart gets a full period
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            age_cnt_q <= 36'h0;
            AGE_TICK  <= 1'b0;
        end else begin
            age_cnt_q <= (!age_en || age_due) ? 36'h0 : age_cnt_q + 36'h1;       // RL1
            AGE_TICK  <= age_due;
        end
    end

    // ****************************************************************
    // Frame size limits
    // ****************************************************************
    logic [10:0]          max_untag_d;  // Untagged limit
    logic [10:0]          max_tag_d;    // Tagged limit
    logic [10:0]          max_untag_q;
    logic [10:0]          max_tag_q;
    logic                 huge;
    logic                 legal_off;

    assign huge        = policy_q[sgp_pkg::PC_HUGE_BIT];
    assign legal_off   = policy_q[sgp_pkg::PC_LEGAL_BIT];
    // Huge support overrides the legal size bit
    assign max_untag_d = huge      ? sgp_pkg::FRAME_HUGE :                       // RL10
                         legal_off ? sgp_pkg::FRAME_LEGAL_OFF :                  // RL11
                                     sgp_pkg::FRAME_UNTAGGED;                    // RL12
    assign max_tag_d   = huge      ? sgp_pkg::FRAME_HUGE :
                         legal_off ? sgp_pkg::FRAME_LEGAL_OFF :
                                     sgp_pkg::FRAME_TAGGED;                      // RL12

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            max_untag_q <= sgp_pkg::FRAME_UNTAGGED;
            max_tag_q   <= sgp_pkg::FRAME_TAGGED;
        end else begin
            max_untag_q <= max_untag_d;
            max_tag_q   <= max_tag_d;
        end
    end

    // ****************************************************************
    // Policy outputs, all straight from flops
    // ****************************************************************
    assign POLICY.age_en          = age_en;
    assign POLICY.fast_age        = fast_en;
    assign POLICY.backoff_aggr    = aging_q[sgp_pkg::AG_BACKOFF_BIT];           // RL3
    assign POLICY.vlan_xing_block = policy_q[sgp_pkg::PC_VLAN_BLOCK_BIT];       // RL4
    assign POLICY.storm_bc_only   = policy_q[sgp_pkg::PC_STORM_BC_BIT];         // RL5
    assign POLICY.bp_carrier      = policy_q[sgp_pkg::PC_BP_CARRIER_BIT];       // RL6
    // Datapath drops when set, flow-controls when clear
    assign POLICY.fair_drop       = policy_q[sgp_pkg::PC_FAIR_BIT];             // RL7 RL8
    assign POLICY.coll_retry      = policy_q[sgp_pkg::PC_COLL_RETRY_BIT];       // RL9
    assign POLICY.prio_reserve    = policy_q[sgp_pkg::PC_PRIO_RSV_BIT];
    assign POLICY.max_untagged    = max_untag_q;
    assign POLICY.max_tagged      = max_tag_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_age_off;
        @(posedge CLOCK) disable iff (!rst_n)
        !age_en |=> !AGE_TICK;
    endproperty
    a_age_off: assert property (p_age_off) else $error("Age tick while aging off"); // RL1

    property p_fast_end;
        @(posedge CLOCK) disable iff (!rst_n)
        fast_done && !wr_aging |=> !POLICY.fast_age ##0 AGE_TICK;
    endproperty
    a_fast_end: assert property (p_fast_end) else $error("Fast age not ended"); // RL13

    property p_huge;
        @(posedge CLOCK) disable iff (!rst_n)
        huge |=> POLICY.max_untagged == sgp_pkg::FRAME_HUGE
            && POLICY.max_tagged == sgp_pkg::FRAME_HUGE;
    endproperty
    a_huge: assert property (p_huge) else $error("Huge limit wrong"); // RL10

    property p_legal;
        @(posedge CLOCK) disable iff (!rst_n)
        !huge && legal_off |=> POLICY.max_untagged == sgp_pkg::FRAME_LEGAL_OFF
            && POLICY.max_tagged == sgp_pkg::FRAME_LEGAL_OFF;
    endproperty
    a_legal: assert property (p_legal) else $error("Legal-off limit wrong"); // RL11

    property p_std;
        @(posedge CLOCK) disable iff (!rst_n)
        !huge && !legal_off |=> POLICY.max_untagged == sgp_pkg::FRAME_UNTAGGED
            && POLICY.max_tagged == sgp_pkg::FRAME_TAGGED;
    endproperty
    a_std: assert property (p_std) else $error("Standard limit wrong"); // RL12

    property p_strap;
        @(posedge CLOCK) disable iff (!rst_n)
        phase_q == sgp_pkg::PH_STRAP |=> POLICY.age_en == $past(AGING_DEFAULT_STRAP_PIN)
            && POLICY.backoff_aggr == $past(BACKOFF_DEFAULT_STRAP_PIN)
            && POLICY.coll_retry == $past(COLLISION_DROP_DEFAULT_STRAP_PIN)
            && legal_off == $past(LEGAL_SIZE_DEFAULT_STRAP_PIN);
    endproperty
    a_strap: assert property (p_strap) else $error("Strap not loaded"); // RL14

    property p_defaults;
        @(posedge CLOCK) disable iff (!rst_n)
        phase_q == sgp_pkg::PH_STRAP |=> policy_q[7:4] == 4'hf && !POLICY.fast_age
            && !huge && !POLICY.prio_reserve;
    endproperty
    a_defaults: assert property (p_defaults) else $error("Reset values wrong"); // RL4

    property p_write;
        @(posedge CLOCK) disable iff (!rst_n)
        wr_policy |=> POLICY.vlan_xing_block == $past(REG_WDATA[7])
            && POLICY.storm_bc_only == $past(REG_WDATA[6])
            && POLICY.bp_carrier == $past(REG_WDATA[5])
            && POLICY.fair_drop == $past(REG_WDATA[4])
            // Read back only owed when the address stayed on this register
            ##1 (REG_RDATA == $past(REG_WDATA, 2)
            || $past(REG_ADDR) != sgp_pkg::REG_POLICY_CTRL_OFS);
    endproperty
    a_write: assert property (p_write) else $error("Policy write not taken"); // RL5

    property p_tick_gap;
        @(posedge CLOCK) disable iff (!rst_n)
        AGE_TICK |=> !AGE_TICK;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("Back to back age ticks"); // RL2

endmodule

// ---- inc/sgp_pkg.sv ----
// ****************************************************************
// Constants and types for the global policy bits
// ****************************************************************
package sgp_pkg;

    // Register map, byte offsets on the management register port
    localparam logic [7:0]  REG_AGING_CTRL_OFS  = 8'h03; // Aging and back-off bits
    localparam logic [7:0]  REG_POLICY_CTRL_OFS = 8'h04; // Switch policy control

    // Field positions in the aging control register
    localparam int          AG_AGE_EN_BIT      = 2;    // Aging enable
    localparam int          AG_FAST_BIT        = 1;    // Fast age enable
    localparam int          AG_BACKOFF_BIT     = 0;    // Aggressive back-off
    localparam logic [2:0]  AG_WRITE_MASK      = 3'h7; // Bits held here, rest read zero

    // Field positions in the policy control register
    localparam int          PC_VLAN_BLOCK_BIT  = 7;    // Port-VLAN mismatch discard
    localparam int          PC_STORM_BC_BIT    = 6;    // Storm protection broadcast only
    localparam int          PC_BP_CARRIER_BIT  = 5;    // Carrier sense back pressure
    localparam int          PC_FAIR_BIT        = 4;    // Flow control fair mode
    localparam int          PC_COLL_RETRY_BIT  = 3;    // No excessive collision drop
    localparam int          PC_HUGE_BIT        = 2;    // Huge packet support
    localparam int          PC_LEGAL_BIT       = 1;    // Legal max size check disable
    localparam int          PC_PRIO_RSV_BIT    = 0;    // Priority buffer reserve

    // Fixed reset values, strap bits are loaded over these after release
    localparam logic [2:0]  AG_RESET           = 3'h4; // Aging on, fast off, back-off off
    localparam logic [7:0]  PC_RESET           = 8'hf0; // Bits 7..4 set, rest clear

    // Frame size limits in bytes
    localparam logic [10:0] FRAME_HUGE         = 11'h77c; // 1916
    localparam logic [10:0] FRAME_LEGAL_OFF    = 11'h600; // 1536
    localparam logic [10:0] FRAME_TAGGED       = 11'h5f2; // 1522
    localparam logic [10:0] FRAME_UNTAGGED     = 11'h5ee; // 1518

    // Aging timing
    localparam longint      CLK_HZ             = 40_000_000;
    localparam longint      AGE_FAST_US        = 800;  // Fast age period, microseconds
    localparam longint      AGE_NORMAL_S       = 300;  // Normal age period, seconds
    localparam longint      AGE_SPREAD_S       = 75;   // Added spread, seconds
    localparam int          AGE_CNT_W          = 36;
    localparam logic [35:0] AGE_FAST_CYC       = 36'(AGE_FAST_US * (CLK_HZ / 1_000_000));
    localparam logic [35:0] AGE_NORMAL_CYC     = 36'((AGE_NORMAL_S + AGE_SPREAD_S) * CLK_HZ);

    // Start-up phase: strap load then normal running
    typedef enum logic [1:0] {
        PH_STRAP = 2'b01,
        PH_RUN   = 2'b10
    } sgp_phase_t;

    // Policy bundle handed to the datapath
    typedef struct packed {
        logic        age_en;          // Address table aging on
        logic        fast_age;        // Fast aging period in use
        logic        backoff_aggr;    // Non-standard back-off
        logic        vlan_xing_block; // No packet crosses a port-VLAN edge
        logic        storm_bc_only;   // Storm control limited to broadcast
        logic        bp_carrier;      // 1 carrier sense, 0 forced collision
        logic        fair_drop;       // Drop from non flow-controlled port
        logic        coll_retry;      // Keep retrying past 16 collisions
        logic        prio_reserve;    // Reserve buffers for high priority
        logic [10:0] max_untagged;    // Largest accepted untagged frame
        logic [10:0] max_tagged;      // Largest accepted tagged frame
    } sgp_policy_t;

endpackage

// ---- test/switch_global_policy_bits_bench.sv ----
`timescale 1ns/100ps
module switch_global_policy_bits_bench;

    // ********************************************************
    // Signals, model state and counters
    // ********************************************************
    localparam int        FAST = 8;     // Shortened fast age period
    localparam int        NORM = 40;    // Shortened normal age period

    logic                 clock;        // Core clock, 40 MHz
    logic                 rst_n;        // Reset, active low
    logic                 strap_age;    // Aging default strap
    logic                 strap_bo;     // Back-off default strap
    logic                 strap_coll;   // Collision retry default strap
    logic                 strap_legal;  // Legal size default strap
    logic [7:0]           reg_addr;     // Register address
    logic                 reg_wr;       // Write strobe
    logic [7:0]           reg_wdata;    // Write data
    logic [7:0]           reg_rdata;    // Read data
    logic                 age_tick;     // Aging pass pulse
    sgp_pkg::sgp_policy_t policy;       // Policy bundle
    int                   err_total;    // Mismatch count
    int                   comparisons;  // Compare count
    integer               seed;         // Random seed
    integer               ag_m;         // Model of aging register
    integer               pc_m;         // Model of policy register
    integer               n;            // Cycle counter
    logic [7:0]           wq[$];        // Write values for policy loop

    // ********************************************************
    // Design under test, short age periods keep the run brief
    // ********************************************************
    sgp_policy_regs #(.FAST_AGE_CYC(36'h8), .NORMAL_AGE_CYC(36'h28)) i_sgp_policy_regs (
        .CLOCK                            (clock),
        .RST_N                            (rst_n),
        .AGING_DEFAULT_STRAP_PIN          (strap_age),
        .BACKOFF_DEFAULT_STRAP_PIN        (strap_bo),
        .COLLISION_DROP_DEFAULT_STRAP_PIN (strap_coll),
        .LEGAL_SIZE_DEFAULT_STRAP_PIN     (strap_legal),
        .REG_ADDR                         (reg_addr),
        .REG_WR                           (reg_wr),
        .REG_WDATA                        (reg_wdata),
        .REG_RDATA                        (reg_rdata),
        .AGE_TICK                         (age_tick),
        .POLICY                           (policy)
    );

    // Free running clock, 25 ns period
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ********************************************************
    // Shared tasks
    // ********************************************************
    // Compare and count, report at once on a miss
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One write cycle, strobe dropped a full cycle later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
    endtask

    // Read answers one edge after the address is shown
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        @(negedge clock);
        d = reg_rdata;
    endtask

    // Count cycles until an aging pulse, bounded
    task automatic wait_tick(input int lim);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (age_tick !== 1'b1 && n < lim);
    endtask

    // Compare both registers and the whole policy bundle with the model
    task automatic check_all();
        logic [7:0] d;
        integer     mu;
        integer     mt;
        mu = pc_m[2] ? 1916 : (pc_m[1] ? 1536 : 1518);
        mt = pc_m[2] ? 1916 : (pc_m[1] ? 1536 : 1522);
        rd(sgp_pkg::REG_AGING_CTRL_OFS, d);
        chk(32'(d), 32'(ag_m & 8'h07), "aging register");
        rd(sgp_pkg::REG_POLICY_CTRL_OFS, d);
        chk(32'(d), 32'(pc_m & 8'hff), "policy register");
        chk({policy.age_en, policy.fast_age, policy.backoff_aggr},
            32'(ag_m & 7), "aging bits");
        chk({policy.vlan_xing_block, policy.storm_bc_only, policy.bp_carrier,
             policy.fair_drop, policy.coll_retry, policy.prio_reserve},
            {pc_m[7:3], pc_m[0]}, "policy bits");
        chk(32'(policy.max_untagged), mu, "untagged limit");
        chk(32'(policy.max_tagged), mt, "tagged limit");
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog, well beyond the expected four hundred or so cycles
    initial begin
        #(25 * 5000);
        err_total++;
        stop_test();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        logic [7:0] d;
        err_total   = 0;
        comparisons = 0;
        seed        = 32'h6af04b63;
        {strap_age, strap_bo, strap_coll, strap_legal} = 4'($random(seed));
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        repeat (16) @(negedge clock);
        chk(32'(reg_rdata), 0, "read data in reset");
        chk(32'(age_tick), 0, "tick in reset");
        chk(32'(policy.max_untagged), 1518, "untagged limit in reset");
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        // Straps land in their bits, fixed defaults elsewhere
        ag_m = {strap_age, 1'b0, strap_bo};
        pc_m = 8'hf0 | {strap_coll, 3'b000} | {strap_legal, 1'b0};
        check_all();
        $display("test reset defaults done");
        // Size limit corners first, then random bytes
        wq = '{8'h00, 8'h02, 8'h04, 8'h06, 8'hff, 8'h0f};
        repeat (6) wq.push_back(8'($random(seed)));
        foreach (wq[k]) begin
            wr(sgp_pkg::REG_POLICY_CTRL_OFS, wq[k]);
            pc_m = wq[k];
            check_all();
        end
        // Unmapped place: write ignored, reads zero
        wr(8'h55, 8'($random(seed)));
        rd(8'h55, d);
        chk(32'(d), 0, "unmapped read");
        check_all();
        $display("test policy register done");
        // Aging register, fast bit kept off here since it clears itself
        repeat (6) begin
            d = 8'($random(seed)) & 8'hfd;
            wr(sgp_pkg::REG_AGING_CTRL_OFS, d);
            ag_m = d & 8'h05;
            check_all();
        end
        $display("test aging register done");
        // Aging off: no pulses at all
        wr(sgp_pkg::REG_AGING_CTRL_OFS, 8'h00);
        ag_m = 0;
        wait_tick(3 * NORM);
        chk(32'(age_tick), 0, "tick while aging off");
        // Fast pass, then back to the normal period
        wr(sgp_pkg::REG_AGING_CTRL_OFS, 8'h06);
        wait_tick(FAST + 4);
        // Counter starts at the write edge, so the pass is exactly one fast period away
        chk(32'(n), FAST, "fast period");
        wait_tick(NORM + 4);
        chk(32'(n), NORM, "period after fast pass");
        wait_tick(NORM + 4);
        chk(32'(n), NORM, "normal period");
        ag_m = 4;
        check_all();
        $display("test aging timing done");
        stop_test();
    end

endmodule
